// ===== hdl/smbm_device.sv
// Device end: bus master port that runs queued memory cycles for the controller.
// Function
// - Drive direction output, float when not master.
// - Flavour A: ready ends cycle, captures read.
// - Flavour B: acknowledge falling edge ends cycle.
// - Bus error terminates current cycle.
// - Control read error: action-fail interrupt, suspend.
// - Transmit read error: abort frame, interrupt.
// - Other bus errors: only terminate cycle.
// - No timeout; bus error escapes hung cycle.
// - Width strap: high 32-bit, low 16-bit.
// - Flavour A: hold request high asks bus.
// - Start cycles only after hold grant.
// - Flavour B: drive request low, sense peers.
// - Arbiter asserts low grant to permit mastership.
// - Drive master-active low; sense other masters.
// - Parity strap fixed before and through reset.
// - Pass hold grant on for downstream requester.
// - Pass unrequested grant; rerequest after lines idle.
// - Low action request pulse starts an action.
// - Host waits 500 us before first action.
// - Flavour A: address strobe low with valid address, else float.
module smbm_device
    import smbm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    smbm_if.device           bus,
    input  wire logic        xfer_valid,
    output logic             xfer_ready,
    input  wire logic        xfer_write,
    input  wire logic [1:0]  xfer_kind,
    input  wire logic [31:0] xfer_addr,
    input  wire logic [31:0] xfer_wdata,
    output logic             done_valid,
    output logic             done_error,
    output logic [31:0]      done_rdata,
    output logic             action_start,
    output logic             action_fail_interrupt,
    output logic             tx_abort_interrupt,
    output logic             action_suspended,
    output logic             parity_mode,
    output logic             wide_mode
);
    typedef enum logic [4:0] {
        SMBM_IDLE  = 5'b00001,
        SMBM_REQ   = 5'b00010,
        SMBM_ADDR  = 5'b00100,
        SMBM_WAIT  = 5'b01000,
        SMBM_REL   = 5'b10000
    } smbm_state_t;

    smbm_state_t state_reg, state_next;
    logic        write_reg, write_next;
    logic [1:0]  kind_reg, kind_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        done_reg, done_next;
    logic        err_reg, err_next;
    logic        afail_reg, afail_next;
    logic        txab_reg, txab_next;
    logic        susp_reg, susp_next;
    logic        ack_prev_reg, ack_prev_next;
    logic        ar_prev_reg, ar_prev_next;
    logic        act_reg, act_next;
    logic        strap_par_reg, strap_par_next;
    logic        strap_wide_reg, strap_wide_next;
    logic        started_reg, started_next;
    logic        flav_b;
    logic        granted;
    logic        terminated;
    logic        ack_fall;
    logic        master;

    assign flav_b   = bus.flavour_select == SMBM_FLAVOUR_B;
    // Flavour B needs the grant and no other master on the shared master-active line.
    assign granted  = flav_b ? (!bus.grant_in_m && bus.master_active_m_i)
                             : bus.hold_grant_in;
    assign ack_fall = ack_prev_reg && !bus.transfer_ack_m;
    // Either acknowledge ends the cycle; bus error is the only escape from a hung cycle.
    assign terminated = (flav_b ? ack_fall : bus.ready_in) || !bus.bus_error_in;
    assign master   = state_reg == SMBM_ADDR || state_reg == SMBM_WAIT;

    // Next-state logic for arbitration and cycles.
    always_comb begin
        state_next      = state_reg;
        write_next      = write_reg;
        kind_next       = kind_reg;
        addr_next       = addr_reg;
        wdata_next      = wdata_reg;
        rdata_next      = rdata_reg;
        done_next       = 1'h0;
        err_next        = 1'h0;
        afail_next      = 1'h0;
        txab_next       = 1'h0;
        susp_next       = susp_reg;
        ack_prev_next   = bus.transfer_ack_m;
        ar_prev_next    = bus.action_request;
        act_next        = 1'h0;
        strap_par_next  = strap_par_reg;
        strap_wide_next = strap_wide_reg;
        started_next    = 1'h1;
        xfer_ready      = 1'h0;
        // Straps are caught once, at the first edge after reset release.
        if (!started_reg) begin
            strap_par_next  = bus.parity_mode_strap;
            strap_wide_next = bus.word_width_select;
        end
        // A falling action request edge starts an action and lifts any suspension.
        if (ar_prev_reg && !bus.action_request) begin
            act_next  = 1'h1;
            susp_next = 1'h0;
        end
        case (state_reg)
            SMBM_IDLE: begin
                // Wait for the hold grant, request and master-active lines to fall idle before requesting again.
                if (xfer_valid && !susp_reg && !bus.hold_grant_in && bus.master_active_m_i
                    && bus.bus_request_m_i) begin
                    state_next = SMBM_REQ;
                end
            end
            SMBM_REQ: begin
                if (granted) begin
                    state_next = SMBM_ADDR;
                end
            end
            SMBM_ADDR: begin
                xfer_ready = 1'h1;
                write_next = xfer_write;
                kind_next  = xfer_kind;
                addr_next  = xfer_addr;
                // Narrow mode leaves the upper data half at zero.
                wdata_next = strap_wide_reg ? xfer_wdata : {16'h0000, xfer_wdata[15:0]};
                state_next = SMBM_WAIT;
            end
            SMBM_WAIT: begin
                if (terminated) begin
                    done_next = 1'h1;
                    if (!bus.bus_error_in) begin
                        err_next = 1'h1;
                        if (!write_reg && kind_reg == SMBM_KIND_CTRL) begin
                            afail_next = 1'h1;
                            susp_next  = 1'h1;
                        end else if (!write_reg && kind_reg == SMBM_KIND_TXDATA) begin
                            txab_next = 1'h1;
                        end
                    end else if (!write_reg) begin
                        rdata_next = strap_wide_reg ? bus.rdata_i : {16'h0000, bus.rdata_i[15:0]};
                    end
                    // Keep mastership while more work is queued and allowed.
                    if (xfer_valid && !(susp_next)) begin
                        state_next = SMBM_ADDR;
                    end else begin
                        state_next = SMBM_REL;
                    end
                end
            end
            SMBM_REL: begin
                state_next = SMBM_IDLE;
            end
            default: begin
                state_next = SMBM_IDLE;
            end
        endcase
    end

    // State registers; only constants are loaded under reset.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg      <= SMBM_IDLE;
            write_reg      <= 1'h0;
            kind_reg       <= SMBM_KIND_OTHER;
            addr_reg       <= SMBM_DATA_RST;
            wdata_reg      <= SMBM_DATA_RST;
            rdata_reg      <= SMBM_DATA_RST;
            done_reg       <= 1'h0;
            err_reg        <= 1'h0;
            afail_reg      <= 1'h0;
            txab_reg       <= 1'h0;
            susp_reg       <= 1'h0;
            ack_prev_reg   <= 1'h1;
            ar_prev_reg    <= 1'h1;
            act_reg        <= 1'h0;
            strap_par_reg  <= 1'h0;
            strap_wide_reg <= 1'h1;
            started_reg    <= 1'h0;
        end else begin
            state_reg      <= state_next;
            write_reg      <= write_next;
            kind_reg       <= kind_next;
            addr_reg       <= addr_next;
            wdata_reg      <= wdata_next;
            rdata_reg      <= rdata_next;
            done_reg       <= done_next;
            err_reg        <= err_next;
            afail_reg      <= afail_next;
            txab_reg       <= txab_next;
            susp_reg       <= susp_next;
            ack_prev_reg   <= ack_prev_next;
            ar_prev_reg    <= ar_prev_next;
            act_reg        <= act_next;
            strap_par_reg  <= strap_par_next;
            strap_wide_reg <= strap_wide_next;
            started_reg    <= started_next;
        end
    end

    // Pin drive: cycle outputs float outside SMBM_WAIT; the flavour B request is driven in SMBM_REQ.
    assign bus.write_not_read_o       = write_reg;
    assign bus.write_not_read_oe_n    = !(state_reg == SMBM_WAIT);
    assign bus.addr_valid_strobe_o    = 1'h0;
    assign bus.addr_valid_strobe_oe_n = !(state_reg == SMBM_WAIT && !flav_b);
    assign bus.addr_o                 = addr_reg;
    assign bus.wdata_o                = wdata_reg;
    assign bus.data_oe_n              = !(state_reg == SMBM_WAIT && write_reg);
    assign bus.hold_request           = !flav_b && (state_reg == SMBM_REQ || master);
    // A grant we did not ask for belongs to a peer further down the chain.
    assign bus.grant_pass_on_i        = !flav_b && bus.hold_grant_in && bus.peer_hold_request
                                        && state_reg == SMBM_IDLE;
    assign bus.bus_request_m_o        = 1'h0;
    assign bus.bus_request_m_oe_n     = !(flav_b && state_reg == SMBM_REQ);
    assign bus.master_active_m_o      = 1'h0;
    assign bus.master_active_m_oe_n   = !(flav_b && master);
    assign bus.grant_pass_on_m        = !(flav_b && !bus.grant_in_m && state_reg == SMBM_IDLE);

    // User-side results.
    assign done_valid            = done_reg;
    assign done_error            = err_reg;
    assign done_rdata            = rdata_reg;
    assign action_start          = act_reg;
    assign action_fail_interrupt = afail_reg;
    assign tx_abort_interrupt    = txab_reg;
    assign action_suspended      = susp_reg;
    assign parity_mode           = strap_par_reg;
    assign wide_mode             = strap_wide_reg;
endmodule

// ===== hdl/smbm_host.sv
// Host end: processor, memory and arbiter, steered over AXI4-Lite.
module smbm_host
    import smbm_pkg::*;
#(
    parameter int AR_WAIT_CYC = SMBM_AR_WAIT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    smbm_if.host             bus,
    input  wire logic [31:0] rdata_src,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [3:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [3:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp
);
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;

    logic [7:0]  ctrl_reg, ctrl_next;
    logic [31:0] wait_reg, wait_next;
    logic [1:0]  pulse_reg, pulse_next;
    logic        awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [3:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    logic        ready_w;

    // Control bits: 0 flavour, 1 width, 2 parity, 3 grant, 4 ready/ack, 5 bus error, 6 peer, 7 action.
    assign ready_w = wait_reg >= 32'(AR_WAIT_CYC);

    // AXI4-Lite slave plus action request pulse timing.
    always_comb begin
        ctrl_next  = ctrl_reg;
        wait_next  = ready_w ? wait_reg : wait_reg + 32'h1;
        pulse_next = pulse_reg == 2'h0 ? 2'h0 : pulse_reg - 2'h1;
        awh_next   = awh_reg;
        wh_next    = wh_reg;
        awa_next   = awa_reg;
        wd_next    = wd_reg;
        bv_next    = bv_reg && !bready;
        br_next    = br_reg;
        rv_next    = rv_reg && !rready;
        rd_next    = rd_reg;
        rr_next    = rr_reg;
        if (awvalid && !awh_reg) begin
            awh_next = 1'h1;
            awa_next = awaddr;
        end
        if (wvalid && !wh_reg) begin
            wh_next = 1'h1;
            wd_next = wdata;
        end
        if (awh_reg && wh_reg && !bv_reg) begin
            awh_next = 1'h0;
            wh_next  = 1'h0;
            bv_next  = 1'h1;
            br_next  = 2'h2;
            if (awa_reg == CTRL_OFS && wstrb[0]) begin
                br_next   = 2'h0;
                ctrl_next = wd_reg[7:0];
                // Action requests before the reset wait are refused.
                if (wd_reg[7] && ready_w) begin
                    pulse_next = 2'(SMBM_AR_PULSE_CYC);
                end
            end
        end
        if (arvalid && !rv_reg) begin
            rv_next = 1'h1;
            rr_next = 2'h0;
            case (araddr)
                CTRL_OFS: rd_next = {24'h000000, ctrl_reg};
                STAT_OFS: rd_next = {26'h0, ready_w, bus.master_active_m_i, bus.bus_request_m_i,
                                     bus.grant_pass_on_i, bus.hold_request, !bus.write_not_read_oe_n};
                default: begin
                    rd_next = 32'h0;
                    rr_next = 2'h2;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_reg  <= 8'h00;
            wait_reg  <= 32'h0;
            pulse_reg <= 2'h0;
            awh_reg   <= 1'h0;
            wh_reg    <= 1'h0;
            bv_reg    <= 1'h0;
            rv_reg    <= 1'h0;
            awa_reg   <= 4'h0;
            wd_reg    <= 32'h0;
            rd_reg    <= 32'h0;
            br_reg    <= 2'h0;
            rr_reg    <= 2'h0;
        end else begin
            ctrl_reg  <= ctrl_next;
            wait_reg  <= wait_next;
            pulse_reg <= pulse_next;
            awh_reg   <= awh_next;
            wh_reg    <= wh_next;
            bv_reg    <= bv_next;
            rv_reg    <= rv_next;
            awa_reg   <= awa_next;
            wd_reg    <= wd_next;
            rd_reg    <= rd_next;
            br_reg    <= br_next;
            rr_reg    <= rr_next;
        end
    end

    assign awready = !awh_reg;
    assign wready  = !wh_reg;
    assign bvalid  = bv_reg;
    assign bresp   = br_reg;
    assign arready = !rv_reg;
    assign rvalid  = rv_reg;
    assign rdata   = rd_reg;
    assign rresp   = rr_reg;

    // Bus-side drive from the control register, the action pulse timer and the read data source.
    assign bus.flavour_select    = ctrl_reg[0];
    assign bus.word_width_select = ctrl_reg[1] | ctrl_reg[2];
    assign bus.parity_mode_strap = ctrl_reg[2];
    assign bus.hold_grant_in     = ctrl_reg[3] && !ctrl_reg[0];
    assign bus.grant_in_m        = !(ctrl_reg[3] && ctrl_reg[0]);
    assign bus.ready_in          = ctrl_reg[4] && !ctrl_reg[0];
    assign bus.transfer_ack_m    = !(ctrl_reg[4] && ctrl_reg[0]);
    assign bus.bus_error_in      = !ctrl_reg[5];
    assign bus.peer_hold_request = ctrl_reg[6];
    assign bus.action_request    = pulse_reg == 2'h0;
    assign bus.rdata_i           = rdata_src;
endmodule

// ===== hdl/smbm_if.sv
// Interface joining the device port and the host side.
interface smbm_if;
    import smbm_pkg::*;
    logic        write_not_read_o;
    logic        write_not_read_oe_n;
    logic        addr_valid_strobe_o;
    logic        addr_valid_strobe_oe_n;
    logic [31:0] addr_o;
    logic [31:0] wdata_o;
    logic [31:0] rdata_i;
    logic        data_oe_n;
    logic        ready_in;
    logic        transfer_ack_m;
    logic        bus_error_in;
    logic        hold_request;
    logic        hold_grant_in;
    logic        grant_pass_on_i;
    logic        bus_request_m_o;
    logic        bus_request_m_oe_n;
    logic        bus_request_m_i;
    logic        grant_in_m;
    logic        master_active_m_o;
    logic        master_active_m_oe_n;
    logic        master_active_m_i;
    logic        grant_pass_on_m;
    logic        word_width_select;
    logic        parity_mode_strap;
    logic        flavour_select;
    logic        action_request;
    logic        peer_hold_request;

    // Wired-OR resolution of the open-drain lines shared with peers.
    assign bus_request_m_i   = bus_request_m_oe_n ? 1'h1 : bus_request_m_o;
    assign master_active_m_i = master_active_m_oe_n ? 1'h1 : master_active_m_o;

    modport device (
        output write_not_read_o, write_not_read_oe_n, addr_valid_strobe_o, addr_valid_strobe_oe_n,
        output addr_o, wdata_o, data_oe_n, hold_request, grant_pass_on_i,
        output bus_request_m_o, bus_request_m_oe_n, master_active_m_o, master_active_m_oe_n, grant_pass_on_m,
        input  rdata_i, ready_in, transfer_ack_m, bus_error_in, hold_grant_in, bus_request_m_i,
        input  grant_in_m, master_active_m_i, word_width_select, parity_mode_strap, flavour_select,
        input  action_request, peer_hold_request
    );
    modport host (
        input  write_not_read_o, write_not_read_oe_n, addr_valid_strobe_o, addr_valid_strobe_oe_n,
        input  addr_o, wdata_o, data_oe_n, hold_request, grant_pass_on_i, grant_pass_on_m,
        input  bus_request_m_i, master_active_m_i,
        output rdata_i, ready_in, transfer_ack_m, bus_error_in, hold_grant_in, grant_in_m,
        output word_width_select, parity_mode_strap, flavour_select, action_request, peer_hold_request
    );
endinterface

// ===== hdl/smbm_pkg.sv
// Shared constants and types for the shared memory bus master port.
package smbm_pkg;
    // Bus flavour encodings used on the strap input.
    localparam logic       SMBM_FLAVOUR_A   = 1'h0;
    localparam logic       SMBM_FLAVOUR_B   = 1'h1;
    // Access kinds that decide what a bus error does.
    localparam logic [1:0] SMBM_KIND_CTRL   = 2'h0;
    localparam logic [1:0] SMBM_KIND_TXDATA = 2'h1;
    localparam logic [1:0] SMBM_KIND_OTHER  = 2'h2;
    // Reset value of the address and data registers.
    localparam logic [31:0] SMBM_DATA_RST   = 32'h0000_0000;
    // Least wait between reset and the first action request.
    localparam int         SMBM_AR_WAIT_US  = 500;
    localparam int         SMBM_CLK_MHZ     = 100;
    localparam int         SMBM_AR_WAIT_CYC = SMBM_AR_WAIT_US * SMBM_CLK_MHZ;
    // Length of the action request low pulse driven by the host.
    localparam int         SMBM_AR_PULSE_CYC = 2;
endpackage

// ===== tb/smbm_props.sv
// Concurrent checks on the device port.
module smbm_props
    import smbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic write_not_read_oe_n,
    input wire logic addr_valid_strobe_oe_n,
    input wire logic hold_request,
    input wire logic hold_grant_in,
    input wire logic grant_pass_on_i,
    input wire logic bus_request_m_oe_n,
    input wire logic bus_request_m_i,
    input wire logic grant_in_m,
    input wire logic master_active_m_oe_n,
    input wire logic master_active_m_i,
    input wire logic grant_pass_on_m,
    input wire logic flavour_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Hold withdrawn: the pins must float.
    sequence s_hold_drop;
        hold_request ##1 !hold_request;
    endsequence

    chk_reset_floats: assert property ($fell(srst) |-> write_not_read_oe_n && bus_request_m_oe_n && !hold_request)
        else $error("pins driven after reset");
    chk_dir_mastered: assert property (!write_not_read_oe_n |->
        ((flavour_select == SMBM_FLAVOUR_A) ? hold_grant_in : !master_active_m_oe_n))
        else $error("drive without mastership");
    chk_strobe_flav_a: assert property (!addr_valid_strobe_oe_n |-> flavour_select == SMBM_FLAVOUR_A)
        else $error("strobe in flavour B");
    chk_hold_flav_a: assert property (hold_request |-> flavour_select == SMBM_FLAVOUR_A)
        else $error("hold in flavour B");
    chk_req_flav_b: assert property (!bus_request_m_oe_n |-> flavour_select == SMBM_FLAVOUR_B)
        else $error("request in flavour A");
    chk_no_rehold: assert property ($rose(hold_request) |-> !$past(hold_grant_in))
        else $error("early hold request");
    chk_rereq_idle: assert property ($fell(bus_request_m_oe_n) |-> $past(bus_request_m_i) && $past(master_active_m_i))
        else $error("request on busy lines");
    chk_pass_on_a: assert property (grant_pass_on_i |-> hold_grant_in || $past(hold_grant_in))
        else $error("stray hold pass-on");
    chk_pass_on_b: assert property (!grant_pass_on_m |-> bus_request_m_oe_n && (!grant_in_m || !$past(grant_in_m)))
        else $error("stray grant pass-on");
    chk_release_floats: assert property (s_hold_drop |-> ##[0:1] (write_not_read_oe_n && addr_valid_strobe_oe_n))
        else $error("pins driven after release");
endmodule

// ===== tb/tb_shared_memory_bus_master_port.sv
// Testbench for the shared memory bus master port.
module tb_shared_memory_bus_master_port;
    timeunit 1ns;
    timeprecision 1ps;
    import smbm_pkg::*;
    logic sys_clk, srst, dev_rst, dev_srst, xfer_valid, xfer_write;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [1:0] xfer_kind, got_resp;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] xfer_addr, xfer_wdata, rdata_src, wdata, got_data, straps;
    logic xfer_ready, done_valid, done_error, action_start, action_fail_interrupt, tx_abort_interrupt;
    logic action_suspended, parity_mode, wide_mode, awready, wready, bvalid, arready, rvalid, last_err;
    logic [1:0] bresp, rresp;
    logic [31:0] done_rdata, rdata;
    int errors, samples_checked, n_done, n_fail, n_abort, n_start, f0, a0;

    smbm_if bus_if();
    // Own device reset, so straps are caught again.
    assign dev_srst = srst | dev_rst;
    smbm_device i_smbm_device(.*, .srst(dev_srst), .bus(bus_if.device));
    smbm_host #(.AR_WAIT_CYC(20)) i_smbm_host(.*, .bus(bus_if.host));
    smbm_props i_smbm_props(.sys_clk(sys_clk), .srst(dev_srst), .write_not_read_oe_n(bus_if.write_not_read_oe_n),
        .addr_valid_strobe_oe_n(bus_if.addr_valid_strobe_oe_n), .hold_request(bus_if.hold_request),
        .hold_grant_in(bus_if.hold_grant_in), .grant_pass_on_i(bus_if.grant_pass_on_i),
        .bus_request_m_oe_n(bus_if.bus_request_m_oe_n), .bus_request_m_i(bus_if.bus_request_m_i),
        .grant_in_m(bus_if.grant_in_m), .master_active_m_oe_n(bus_if.master_active_m_oe_n),
        .master_active_m_i(bus_if.master_active_m_i), .grant_pass_on_m(bus_if.grant_pass_on_m),
        .flavour_select(bus_if.flavour_select));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // One-cycle pulses are counted here.
    always @(posedge sys_clk) begin
        if (xfer_valid && xfer_ready === 1'h1) xfer_valid <= 1'h0;
        if (done_valid === 1'h1) begin
            n_done <= n_done + 1;
            last_err <= done_error;
        end
        if (action_fail_interrupt === 1'h1) n_fail <= n_fail + 1;
        if (tx_abort_interrupt === 1'h1) n_abort <= n_abort + 1;
        if (action_start === 1'h1) n_start <= n_start + 1;
    end

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask

    // AW and W go together; each drops when taken.
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic aw_done = 1'h0, w_done = 1'h0;
        @(posedge sys_clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk);
            if (!aw_done && awready === 1'h1) begin aw_done = 1'h1; awvalid <= 1'h0; end
            if (!w_done && wready === 1'h1) begin w_done = 1'h1; wvalid <= 1'h0; end
        end
        while (bvalid !== 1'h1) @(posedge sys_clk);
        got_resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic axr(input logic [3:0] a);
        @(posedge sys_clk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do @(posedge sys_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge sys_clk);
        got_data = rdata;
        got_resp = rresp;
        rready <= 1'h0;
    endtask

    // One memory cycle from request to release.
    task automatic run(input logic fl, input logic w, input logic [1:0] kind, input logic [31:0] term,
                       input logic [31:0] src, input logic hang);
        int n0;
        logic [31:0] base;
        base = straps | {31'h0, fl};
        n0 = n_done;
        rdata_src <= src;
        axw(4'h0, base);
        @(posedge sys_clk);
        xfer_write <= w; xfer_kind <= kind; xfer_addr <= 32'h0000_0100; xfer_wdata <= src; xfer_valid <= 1'h1;
        if (fl == SMBM_FLAVOUR_A) while (bus_if.hold_request !== 1'h1) @(posedge sys_clk);
        else while (bus_if.bus_request_m_i !== 1'h0) @(posedge sys_clk);
        cmp_bit(bus_if.write_not_read_oe_n, 1'h1);
        axw(4'h0, base | 32'h8);
        while (bus_if.write_not_read_oe_n !== 1'h0) @(posedge sys_clk);
        cmp_bit(bus_if.write_not_read_o, w);
        cmp_bit(bus_if.master_active_m_oe_n, ~fl);
        if (hang) begin
            repeat (40) @(posedge sys_clk);
            cmp_bit(n_done == n0, 1'h1);
        end
        axw(4'h0, base | 32'h8 | term);
        while (n_done == n0) @(posedge sys_clk);
        axw(4'h0, base);
        repeat (3) @(posedge sys_clk);
        cmp_bit(bus_if.write_not_read_oe_n, 1'h1);
    endtask

    initial begin
        {xfer_valid, xfer_write, awvalid, wvalid, bready, arvalid, rready, dev_rst, last_err} = '0;
        {xfer_kind, awaddr, araddr, wstrb, xfer_addr, xfer_wdata, rdata_src, wdata, straps} = '0;
        {errors, samples_checked, n_done, n_fail, n_abort, n_start} = '0;
        srst = 1'h1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        cmp_bit(wide_mode, 1'h0);
        cmp_bit(parity_mode, 1'h0);
        axr(4'h4);
        cmp_word(got_data & 32'h3, 32'h0);
        axr(4'h8);
        cmp_word({30'h0, got_resp}, 32'h2);
        run(SMBM_FLAVOUR_A, 1'h0, SMBM_KIND_OTHER, 32'h10, 32'hA5A5_1234, 1'h0);
        cmp_bit(last_err, 1'h0);
        cmp_word(done_rdata, 32'h0000_1234);
        run(SMBM_FLAVOUR_A, 1'h1, SMBM_KIND_OTHER, 32'h10, 32'h0000_BEEF, 1'h0);
        cmp_bit(last_err, 1'h0);
        straps = 32'h6;
        axw(4'h0, straps);
        @(posedge sys_clk) dev_rst <= 1'h1;
        @(posedge sys_clk) dev_rst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        cmp_bit(wide_mode, 1'h1);
        cmp_bit(parity_mode, 1'h1);
        run(SMBM_FLAVOUR_B, 1'h0, SMBM_KIND_OTHER, 32'h10, 32'h5A5A_C3C3, 1'h0);
        cmp_bit(last_err, 1'h0);
        cmp_word(done_rdata, 32'h5A5A_C3C3);
        run(SMBM_FLAVOUR_B, 1'h1, SMBM_KIND_OTHER, 32'h10, 32'h1357_9BDF, 1'h0);
        cmp_bit(last_err, 1'h0);
        f0 = n_fail;
        run(SMBM_FLAVOUR_B, 1'h0, SMBM_KIND_CTRL, 32'h20, 32'h0, 1'h1);
        cmp_bit(last_err, 1'h1);
        cmp_bit(n_fail == f0 + 1, 1'h1);
        cmp_bit(action_suspended, 1'h1);
        a0 = n_start;
        axw(4'h0, straps | 32'h81);
        while (n_start == a0) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        cmp_bit(action_suspended, 1'h0);
        a0 = n_abort;
        run(SMBM_FLAVOUR_A, 1'h0, SMBM_KIND_TXDATA, 32'h20, 32'h0, 1'h0);
        cmp_bit(n_abort == a0 + 1, 1'h1);
        run(SMBM_FLAVOUR_A, 1'h1, SMBM_KIND_OTHER, 32'h20, 32'h0, 1'h0);
        cmp_bit(last_err, 1'h1);
        cmp_bit(n_abort == a0 + 1 && n_fail == f0 + 1, 1'h1);
        axw(4'h0, straps | 32'h48);
        repeat (3) @(posedge sys_clk);
        cmp_bit(bus_if.grant_pass_on_i, 1'h1);
        axw(4'h0, straps | 32'h9);
        repeat (3) @(posedge sys_clk);
        cmp_bit(bus_if.grant_pass_on_m, 1'h0);
        axw(4'h0, straps | 32'h1);
        repeat (3) @(posedge sys_clk);
        cmp_bit(bus_if.grant_pass_on_m, 1'h1);
        print_verdict();
    end

    // Runs need a few hundred cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("Error at %0t: timeout", $time);
        print_verdict();
    end
endmodule
